// [ccd_decoder.sv]
// Purpose: per-channel command register decoder behind an APB slave
// Assumes: single clock, asynchronous active-high reset
// Notes:   every output is registered; slave answers with zero wait states
// Functional notes
// - low nibble only enables/disables tx and rx
// - codes 1 to B touch only written channel
// - codes C and D act chip-wide
// - code 1 returns mode pointer to first
// - code 2 resets receiver, disables, flushes fifo
// - code 3 resets transmitter as hardware reset
// - transmitter reset forces serial output high
// - control field 00 keep, 01 on, 10 off
// - first mode access moves pointer to second
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
module ccd_decoder
    import ccd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [1:0]       tx_enable,
    output logic [1:0]       rx_enable,
    output logic [1:0]       rx_fifo_flush,
    output logic [1:0]       serial_transmit_output,
    output logic [1:0]       mode_register_pointer,
    output logic             chip_cmd_pulse,
    output logic [3:0]       chip_cmd_code
);

    typedef enum logic {CCD_IDLE, CCD_ACCESS} ccd_phase_e;

    typedef struct packed {
        ccd_phase_e  phase;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [1:0]  tx_en;
        logic [1:0]  rx_en;
        logic [1:0]  flush;
        logic [1:0]  txd;
        logic [1:0]  ptr;       // 1 = pointing at second mode register
        logic [7:0]  mode1_a;
        logic [7:0]  mode2_a;
        logic [7:0]  mode1_b;
        logic [7:0]  mode2_b;
        logic        chip_pulse;
        logic [3:0]  chip_code;
    } ccd_state_s;

    ccd_state_s state_reg;
    ccd_state_s state_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // apply a two-bit enable/disable field to a current enable
    function automatic logic ccd_apply_ctl(input logic [1:0] f, input logic cur);
        logic r;
        r = cur;
        case (f)
            CCD_CTL_ENABLE:  r = 1'b1;
            CCD_CTL_DISABLE: r = 1'b0;
            default:         r = cur;  // keep, and the invalid code is ignored
        endcase
        return r;
    endfunction

    function automatic logic ccd_is_cmd(input logic [7:0] a);
        return (a == CCD_OFF_CMD_A) || (a == CCD_OFF_CMD_B);
    endfunction

    // the access edge is honoured only in the cycle after a setup cycle,
    // so a master that skips setup never changes anything
    logic access_go;
    always_comb begin
        case (state_reg.phase)
            CCD_ACCESS: access_go = psel && penable && state_reg.ready;
            default:    access_go = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] cmd;
        logic       ch;
        logic       known;
        cmd   = pwdata[7:0];
        ch    = (paddr == CCD_OFF_CMD_B);
        known = 1'b0;
        state_next = state_reg;
        state_next.flush      = 2'b00;
        state_next.chip_pulse = 1'b0;
        // one wait-free answer: ready rises in the access phase, falls after
        state_next.ready  = psel && !penable;
        state_next.slverr = 1'b0;
        state_next.phase  = (psel && !penable) ? CCD_ACCESS : CCD_IDLE;
        if (psel && !penable) begin
            known = ccd_is_cmd(paddr) || paddr == CCD_OFF_MODE_A
                    || paddr == CCD_OFF_MODE_B || paddr == CCD_OFF_STATUS;
            state_next.slverr = !known;
            state_next.rdata  = CCD_ZERO;
            if (!pwrite) begin
                case (paddr)
                    CCD_OFF_MODE_A: state_next.rdata[7:0] =
                        state_reg.ptr[0] ? state_reg.mode2_a : state_reg.mode1_a;
                    CCD_OFF_MODE_B: state_next.rdata[7:0] =
                        state_reg.ptr[1] ? state_reg.mode2_b : state_reg.mode1_b;
                    CCD_OFF_STATUS: begin
                        for (int i = 0; i < 2; i++) begin
                            state_next.rdata[CCD_ST_TX_EN + i*CCD_ST_STRIDE] =
                                state_reg.tx_en[i];
                            state_next.rdata[CCD_ST_RX_EN + i*CCD_ST_STRIDE] =
                                state_reg.rx_en[i];
                            state_next.rdata[CCD_ST_PTR + i*CCD_ST_STRIDE] =
                                state_reg.ptr[i];
                            state_next.rdata[CCD_ST_TXD + i*CCD_ST_STRIDE] =
                                state_reg.txd[i];
                        end
                        state_next.rdata[CCD_ST_CHIP +: 4] = state_reg.chip_code;
                    end
                    default: state_next.rdata = CCD_ZERO;
                endcase
            end
        end
        if (access_go) begin
            // mode register access: pointer moves to second after first
            if (paddr == CCD_OFF_MODE_A) begin
                if (pwrite && !state_reg.ptr[0]) state_next.mode1_a = pwdata[7:0];
                if (pwrite && state_reg.ptr[0]) state_next.mode2_a = pwdata[7:0];
                state_next.ptr[0] = 1'b1;
            end
            if (paddr == CCD_OFF_MODE_B) begin
                if (pwrite && !state_reg.ptr[1]) state_next.mode1_b = pwdata[7:0];
                if (pwrite && state_reg.ptr[1]) state_next.mode2_b = pwdata[7:0];
                state_next.ptr[1] = 1'b1;
            end
            if (pwrite && ccd_is_cmd(paddr)) begin
                // low nibble: only enables of the written channel
                state_next.tx_en[ch] = ccd_apply_ctl(cmd[1:0], state_reg.tx_en[ch]);
                state_next.rx_en[ch] = ccd_apply_ctl(cmd[3:2], state_reg.rx_en[ch]);
                case (cmd[7:4])
                    CCD_CMD_NULL: ;
                    CCD_CMD_RST_PTR: state_next.ptr[ch] = 1'b0;
                    CCD_CMD_RST_RX: begin
                        state_next.rx_en[ch] = 1'b0;
                        state_next.flush[ch] = 1'b1;
                    end
                    CCD_CMD_RST_TX: begin
                        state_next.tx_en[ch] = 1'b0;
                        state_next.txd[ch]   = 1'b1;
                    end
                    CCD_CMD_CHIP_LO, CCD_CMD_CHIP_HI: begin
                        // chip-wide: reported on a shared strobe, not per channel
                        state_next.chip_pulse = 1'b1;
                        state_next.chip_code  = cmd[7:4];
                    end
                    default: ; // other channel codes live in other blocks
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg       <= '0;
            state_reg.phase <= CCD_IDLE;
            state_reg.txd   <= 2'b11; // idle line is high
            state_reg.mode1_a <= CCD_MODE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata                 = state_reg.rdata;
    assign pready                 = state_reg.ready;
    assign pslverr                = state_reg.slverr;
    assign tx_enable              = state_reg.tx_en;
    assign rx_enable              = state_reg.rx_en;
    assign rx_fifo_flush          = state_reg.flush;
    assign serial_transmit_output = state_reg.txd;
    assign mode_register_pointer  = state_reg.ptr;
    assign chip_cmd_pulse         = state_reg.chip_pulse;
    assign chip_cmd_code          = state_reg.chip_code;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a completed access: the edge at which a bus write takes effect
    sequence s_access;
        psel && penable && pready;
    endsequence

    // a completed command write carrying one upper-nibble code
    sequence s_cmd_write(int unsigned off, logic [3:0] code);
        s_access ##0 (pwrite && paddr == off && pwdata[7:4] == code);
    endsequence

    // a completed command write of one channel, whatever the code
    sequence s_any_cmd(int unsigned off);
        s_access ##0 (pwrite && paddr == off);
    endsequence

    // bus answer: ready follows every setup cycle
    a_setup_answer: assert property (@(posedge clk) disable iff (rst)
        psel && !penable |=> pready)
        else $error("no answer after setup");

    // ready stands one cycle only, so back-to-back transfers stay apart
    a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
        pready |=> !pready)
        else $error("ready held too long");

    // a refused access must leave every channel as it was
    a_refused_quiet: assert property (@(posedge clk) disable iff (rst)
        s_access ##0 pslverr |=> $stable(tx_enable) && $stable(rx_enable)
        && $stable(mode_register_pointer) && !chip_cmd_pulse)
        else $error("refused access had effect");

    // receiver reset: flush pulse and disable on the written channel only
    a_rxrst_flush: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_RST_RX) |=> rx_fifo_flush[0] && !rx_enable[0]
        && rx_fifo_flush[1] == 1'b0)
        else $error("rx reset did not flush");

    // transmitter reset drops the enable and holds the line high
    a_txrst_high: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_B, CCD_CMD_RST_TX) |=> serial_transmit_output[1]
        && !tx_enable[1])
        else $error("tx reset did not force line high");

    a_txrst_chan_a: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_RST_TX) |=> serial_transmit_output[0]
        && !tx_enable[0])
        else $error("tx reset of channel a incomplete");

    // pointer: back to first on command, to second after a mode access
    a_ptr_reset: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_RST_PTR) |=> !mode_register_pointer[0])
        else $error("pointer not returned");

    a_ptr_advance: assert property (@(posedge clk) disable iff (rst)
        s_access ##0 (paddr == CCD_OFF_MODE_B) |=> mode_register_pointer[1])
        else $error("pointer did not advance");

    // once on the second register the pointer stays until a reset command
    a_ptr_sticky: assert property (@(posedge clk) disable iff (rst)
        mode_register_pointer[0] && !(psel && penable && pready && pwrite
        && paddr == CCD_OFF_CMD_A && pwdata[7:4] == CCD_CMD_RST_PTR)
        |=> mode_register_pointer[0])
        else $error("pointer left the second register");

    // a command for channel a never reaches channel b
    a_other_untouched: assert property (@(posedge clk) disable iff (rst)
        s_any_cmd(CCD_OFF_CMD_A) |=> $stable(tx_enable[1]) && $stable(rx_enable[1])
        && !rx_fifo_flush[1] && $stable(mode_register_pointer[1]))
        else $error("other channel changed");

    // codes 4 to B belong to other blocks: only the low-nibble enables may move
    a_codes_inert: assert property (@(posedge clk) disable iff (rst)
        s_any_cmd(CCD_OFF_CMD_B) ##0 (pwdata[7:4] > CCD_CMD_RST_TX
        && pwdata[7:4] < CCD_CMD_CHIP_LO) |=> $stable(mode_register_pointer)
        && !chip_cmd_pulse && rx_fifo_flush == 2'b00 && $stable(serial_transmit_output))
        else $error("inert code had effect");

    // chip-wide codes raise the shared strobe and leave the channels alone apart from the low-nibble enables
    a_chip_strobe: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_B, CCD_CMD_CHIP_HI) |=> chip_cmd_pulse
        && chip_cmd_code == CCD_CMD_CHIP_HI && $stable(mode_register_pointer))
        else $error("chip command lost");

    a_chip_code_lo: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_CHIP_LO) |=> chip_cmd_pulse
        && chip_cmd_code == CCD_CMD_CHIP_LO && rx_fifo_flush == 2'b00)
        else $error("chip command c lost");

    // low nibble with a null code: enables follow the two fields
    a_tx_enable: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_NULL) ##0 (pwdata[1:0] == CCD_CTL_ENABLE)
        |=> tx_enable[0])
        else $error("tx enable missed");

    a_tx_keep: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_NULL) ##0 (pwdata[1:0] == CCD_CTL_KEEP)
        |=> $stable(tx_enable[0]))
        else $error("tx keep changed the enable");

    a_rx_disable: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_B, CCD_CMD_NULL) ##0 (pwdata[3:2] == CCD_CTL_DISABLE)
        |=> !rx_enable[1])
        else $error("rx disable missed");

    // a null code changes nothing beyond the enables
    a_null_quiet: assert property (@(posedge clk) disable iff (rst)
        s_cmd_write(CCD_OFF_CMD_A, CCD_CMD_NULL) |=> $stable(mode_register_pointer)
        && !chip_cmd_pulse && rx_fifo_flush == 2'b00)
        else $error("null had effect");

endmodule

// [ccd_pkg.sv]
// Purpose: constants for the channel command decoder
// Assumes: 32-bit APB, one register per aligned word
// Notes:   offsets are byte addresses
package ccd_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CCD_OFF_CMD_A    = 8'h00;
    localparam logic [7:0] CCD_OFF_CMD_B    = 8'h04;
    localparam logic [7:0] CCD_OFF_MODE_A   = 8'h08;
    localparam logic [7:0] CCD_OFF_MODE_B   = 8'h0C;
    localparam logic [7:0] CCD_OFF_STATUS   = 8'h10;
    // ------------------------------------------------------------
    // command byte fields and codes
    // ------------------------------------------------------------
    localparam logic [1:0] CCD_CTL_KEEP     = 2'h0;
    localparam logic [1:0] CCD_CTL_ENABLE   = 2'h1;
    localparam logic [1:0] CCD_CTL_DISABLE  = 2'h2;
    localparam logic [1:0] CCD_CTL_INVALID  = 2'h3;
    localparam logic [3:0] CCD_CMD_NULL     = 4'h0;
    localparam logic [3:0] CCD_CMD_RST_PTR  = 4'h1;
    localparam logic [3:0] CCD_CMD_RST_RX   = 4'h2;
    localparam logic [3:0] CCD_CMD_RST_TX   = 4'h3;
    localparam logic [3:0] CCD_CMD_CHIP_LO  = 4'hC;
    localparam logic [3:0] CCD_CMD_CHIP_HI  = 4'hD;
    localparam logic [7:0] CCD_MODE_RESET   = 8'h00;
    localparam logic [31:0] CCD_ZERO        = 32'h0000_0000;
    // status bit positions per channel (channel b adds CCD_ST_STRIDE)
    localparam int CCD_ST_TX_EN   = 0;
    localparam int CCD_ST_RX_EN   = 1;
    localparam int CCD_ST_PTR     = 2;
    localparam int CCD_ST_TXD     = 3;
    localparam int CCD_ST_STRIDE  = 4;
    localparam int CCD_ST_CHIP    = 8;
endpackage

// [ccd_host.sv]
// Purpose: host model that issues APB transfers to the command decoder
// Assumes: one clock; the slave may insert up to 63 wait states
// Notes:   idle address and data are inverted so stale values never look valid
module ccd_host (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // bus idle state at time zero
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hFFFF_FFFF;
    end
    // ------------------------------------------------------------
    // one transfer: setup, access until pready, then release
    // ------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata, output logic err, output logic done);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        // bounded wait so a dead slave cannot hang the run
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        done = (pready === 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~data;
    endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the channel command decoder
// Assumes: outputs settle one time unit after the access edge
// Notes:   output snapshot packs {tx_enable, rx_enable, txd, pointer}
module testbench
    import ccd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, chip_cmd_pulse, ok, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [1:0]  tx_enable, rx_enable, rx_fifo_flush, serial_transmit_output;
    logic [1:0]  mode_register_pointer;
    logic [3:0]  chip_cmd_code;
    int          bad_count, total_checks;
    ccd_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ccd_decoder dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .rx_fifo_flush(rx_fifo_flush),
        .serial_transmit_output(serial_transmit_output),
        .mode_register_pointer(mode_register_pointer),
        .chip_cmd_pulse(chip_cmd_pulse), .chip_cmd_code(chip_cmd_code));
    // ------------------------------------------------------------
    // clock, 50 ns period
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask
    // a hung transfer counts against the run and ends it
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        host.xfer(wr, addr, data, rdata, err, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            conclude();
        end
        #1;
    endtask
    task automatic outs(input logic [7:0] exp);
        check({24'h0, tx_enable, rx_enable, serial_transmit_output, mode_register_pointer},
              {24'h0, exp});
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        total_checks = 0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        outs(8'h0C);
        bus(1'b0, CCD_OFF_STATUS, CCD_ZERO);
        check(rdata, (32'h1 << CCD_ST_TXD) | (32'h1 << (CCD_ST_TXD + CCD_ST_STRIDE)));
        bus(1'b1, CCD_OFF_CMD_A, 32'hFFFF_FF05);
        outs(8'h5C);
        // field 00 keeps tx on while rx is switched off; 11 is never sent
        bus(1'b1, CCD_OFF_CMD_A, 32'h0000_0008);
        outs(8'h4C);
        bus(1'b1, CCD_OFF_CMD_B, 32'h0000_0005);
        outs(8'hEC);
        bus(1'b0, CCD_OFF_MODE_A, CCD_ZERO);
        check(rdata, {24'h0, CCD_MODE_RESET});
        outs(8'hED);
        bus(1'b1, CCD_OFF_MODE_B, 32'h0000_0012);
        outs(8'hEF);
        bus(1'b1, CCD_OFF_CMD_A, 32'h0000_0010);
        outs(8'hEE);
        // enable plus receiver reset in one byte: the reset wins
        bus(1'b1, CCD_OFF_CMD_A, 32'h0000_0024);
        check({30'h0, rx_fifo_flush}, 32'h1);
        outs(8'hEE);
        @(posedge clk);
        #1;
        check({30'h0, rx_fifo_flush}, 32'h0);
        bus(1'b1, CCD_OFF_CMD_A, 32'h0000_0031);
        outs(8'hAE);
        check({30'h0, serial_transmit_output}, 32'h3);
        // codes 4 to B act on nothing this block owns
        for (int c = 4; c <= 11; c++) begin
            bus(1'b1, CCD_OFF_CMD_B, {24'h0, c[3:0], 4'h0});
            outs(8'hAE);
            check({31'h0, chip_cmd_pulse}, 32'h0);
        end
        bus(1'b1, CCD_OFF_CMD_A, {24'h0, CCD_CMD_CHIP_LO, 4'h0});
        check({27'h0, chip_cmd_pulse, chip_cmd_code}, {27'h1, CCD_CMD_CHIP_LO});
        bus(1'b1, CCD_OFF_CMD_B, {24'h0, CCD_CMD_CHIP_HI, 4'h0});
        check({27'h0, chip_cmd_pulse, chip_cmd_code}, {27'h1, CCD_CMD_CHIP_HI});
        outs(8'hAE);
        // transmitter reset on channel b drops only its tx enable
        bus(1'b1, CCD_OFF_CMD_B, 32'h0000_0030);
        outs(8'h2E);
        bus(1'b1, CCD_OFF_CMD_B, 32'h0000_000A);
        outs(8'h0E);
        check({29'h0, chip_cmd_pulse, rx_fifo_flush}, 32'h0);
        bus(1'b1, 8'h20, 32'h0000_0005);
        check({31'h0, err}, 32'h1);
        outs(8'h0E);
        bus(1'b0, CCD_OFF_CMD_A, CCD_ZERO);
        check(rdata, CCD_ZERO);
        // a reset in mid-run brings back the power-up state
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        outs(8'h0C);
        conclude();
    end
endmodule
